// File: verilog/pa_mon_pkg.sv
// Purpose: Shared constants and carriers for the monitor register bank
// Assumes: 16-bit registers, 24-bit serial frames {read, addr[6:0], data[15:0]}
// Notes: Read data of a read frame are shifted out in the following frame
package pa_mon_pkg;
    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 24;
    localparam int CNT_W = 5;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 7;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_PWR = 7'h08;
    localparam logic [6:0] ADDR_GLOBAL = 7'h17;
    localparam logic [6:0] ADDR_SENSE0 = 7'h18;
    localparam logic [6:0] ADDR_SENSE1 = 7'h19;
    localparam logic [6:0] ADDR_HV0 = 7'h1A;
    localparam logic [6:0] ADDR_HV1 = 7'h1B;
    localparam logic [6:0] ADDR_TEMP = 7'h1C;
    localparam logic [6:0] ADDR_STATUS = 7'h20;
    localparam logic [6:0] ADDR_ALM_STAT0 = 7'h21;
    localparam logic [6:0] ADDR_ALM_STAT1 = 7'h22;
    localparam logic [6:0] ADDR_ADC_OVR = 7'h23;
    localparam logic [6:0] ADDR_ID = 7'h40;
    localparam logic [6:0] ADDR_VER = 7'h41;
    localparam logic [6:0] ADDR_SDO = 7'h42;
    localparam logic [6:0] ADDR_CFG0 = 7'h44;
    localparam logic [6:0] ADDR_CFG1 = 7'h45;
    localparam logic [6:0] ADDR_ASRC0 = 7'h48;
    localparam logic [6:0] ADDR_ASRC1 = 7'h49;
    localparam logic [6:0] ADDR_BYP0 = 7'h4C;
    localparam logic [6:0] ADDR_BYP1 = 7'h4D;
    localparam logic [6:0] ADDR_PSRC0 = 7'h50;
    localparam logic [6:0] ADDR_PSRC1 = 7'h51;
    localparam logic [6:0] ADDR_RFLAGS = 7'h70;
    // ------------------------------------------------------------
    // Writable masks and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] MASK_GLOBAL = 16'h0003;
    localparam logic [15:0] MASK_PWR = 16'h01FF;
    localparam logic [15:0] MASK_SDO = 16'h0003;
    localparam logic [15:0] MASK_CFG0 = 16'hC038;
    localparam logic [15:0] MASK_CFG1 = 16'h773F;
    localparam logic [15:0] MASK_ALM0 = 16'h0133;
    localparam logic [15:0] MASK_ALM1 = 16'h3833;
    localparam logic [15:0] MASK_SRC1 = 16'h1833;
    localparam logic [15:0] MASK_RFLAGS = 16'h000F;
    localparam logic [15:0] MASK_VER = 16'h000F;
    localparam logic [15:0] RST_CFG0 = 16'h0010;
    localparam logic [15:0] RST_CFG1 = 16'h1101;
    localparam logic [15:0] RST_SRC1 = 16'h1833;
    localparam logic [15:0] RST_RFLAGS = 16'h000F;
    localparam logic [15:0] ZERO16 = 16'h0000;
    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int GLB_ALARM_OVR = 0;
    localparam int GLB_ADC_OVR = 1;
    localparam int SERIAL_OUT_CONTROL_BIT = 0;
    localparam int SDO_EARLY_BIT = 1;
    localparam int AMP_POL_BIT = 15;
    localparam int AMP_OD_BIT = 14;
    localparam int MP_POL_BIT = 5;
    localparam int MP_OD_BIT = 4;
    localparam int HOLD_DIS_BIT = 3;
    localparam int VSSB_LO = 12;
    localparam int VSSA_LO = 8;
    localparam int PWR_AMP_BIT = 8;
    localparam int VSSA_ALM_BIT = 4;
    localparam int VSSB_ALM_BIT = 5;
    localparam int RFLAG_W = 4;
    localparam logic [5:0] FUNC_ALARM_OUT = 6'h02;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } frame_s;
    typedef struct packed {
        logic [DATA_W-1:0] sense0;
        logic [DATA_W-1:0] sense1;
        logic [DATA_W-1:0] hv0;
        logic [DATA_W-1:0] hv1;
        logic [DATA_W-1:0] temp;
    } adc_in_s;
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [FRAME_BITS-2:0] shift;
    } link_fall_s;
endpackage

// File: verilog/spi_link_port.sv
// Purpose: Serial link end running on the host's serial clock
// Assumes: Serial clock idles high, input sampled on falling edges
// Notes: Counters are cleared by chip select high; frame word held for ref domain
`timescale 1ns/1ps
`default_nettype none
module spi_link_port (
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    input wire logic reset_n_i,
    input wire logic early_i,
    input wire logic [15:0] read_word_i,
    output logic sdo_o,
    output var pa_mon_pkg::frame_s frame_o,
    output logic done_tgl_o
);
    // ------------------------------------------------------------
    // Falling edge: input shift and bit count
    // ------------------------------------------------------------
    pa_mon_pkg::link_fall_s fall_reg, fall_next;
    logic [pa_mon_pkg::CNT_W-1:0] rise_cnt_reg;
    logic [pa_mon_pkg::CNT_W-1:0] out_idx;
    logic [pa_mon_pkg::FRAME_BITS-1:0] out_word;
    localparam logic [pa_mon_pkg::CNT_W-1:0] LAST =
        pa_mon_pkg::CNT_W'(pa_mon_pkg::FRAME_BITS - 1);

    always_comb begin
        fall_next.shift = {fall_reg.shift[pa_mon_pkg::FRAME_BITS-3:0], sdi_i};
        fall_next.cnt = (fall_reg.cnt > LAST) ? fall_reg.cnt : fall_reg.cnt + 1'b1;
    end

    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            fall_reg <= '0;
        end else begin
            fall_reg <= fall_next;
        end
    end

    always_ff @(negedge sclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            frame_o <= '0;
            done_tgl_o <= 1'b0;
        end else if (fall_reg.cnt == LAST) begin
            frame_o <= {fall_reg.shift, sdi_i};
            done_tgl_o <= ~done_tgl_o;
        end
    end

    // ------------------------------------------------------------
    // Rising edge count for normal output timing
    // ------------------------------------------------------------
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            rise_cnt_reg <= '0;
        end else if (rise_cnt_reg <= LAST) begin
            rise_cnt_reg <= rise_cnt_reg + 1'b1;
        end
    end

    assign out_idx = early_i ? fall_reg.cnt : rise_cnt_reg;
    // Bit out of the held read word; upper byte reads zero
    assign out_word = {8'h00, read_word_i};
    assign sdo_o = (out_idx <= LAST) ? out_word[LAST - out_idx] : 1'b0;
endmodule
`default_nettype wire

// File: verilog/pa_monitor_general_config_regs.sv
// Purpose: Monitor result, override, pin option and alarm routing registers
// Assumes: Host reaches the bank through the serial link on sclk_i
// Notes: Inputs other than the link come from logic on ref_clk_i
// How it works
// - ADC override set makes every result register read the stored override value.
// - Alarm override set replaces all alarm states with override values.
// - Shunt results pass as 16-bit two's complement, scale set by gain.
// - High-voltage results pass as 16-bit non-negative two's complement.
// - Die temperature result passes as 16-bit two's complement.
// - Normal mode: first bit at select fall, next bits on rising edges.
// - Early mode: first bit at select fall, next bits on falling edges.
// - Early mode means nothing while serial output is disabled.
// - Output driven only when enabled, select low and not in I2C mode.
// - Amplifier pin follows power bit, inverted when polarity bit set.
// - Amplifier pin push-pull by default, open-drain when its bit set.
// - Multi pin output active low at polarity 0, high at 1.
// - Multi pin push-pull at 0, open-drain at 1; resets to open-drain.
// - Latched alarm holds until status read after the condition cleared.
// - Unlatched alarm follows the condition directly.
// - Group B window one-hot; supply outside it raises group B alarm.
// - Group A window one-hot; supply outside it raises group A alarm.
// - Multi pin function one-hot field, resets to the reset role.
// - Under alarm override each override bit forces its alarm status.
// - Shutdown mask bits let alarms switch the amplifier pin off.
// - Alarm-output mask bits let alarms assert the alarm pin.
// - Software arms a cause flag with 0; its event sets it to 1.
`timescale 1ns/1ps
`default_nettype none
module pa_monitor_general_config_regs #(
    parameter logic [15:0] DEVICE_ID = 16'h5A5A, // Arbitrary value
    parameter logic [3:0] REVISION = 4'h7 // Arbitrary value
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    input wire logic i2c_mode_i,
    input wire pa_mon_pkg::adc_in_s adc_i,
    input wire logic [15:0] alarm_raw0_i,
    input wire logic [15:0] alarm_raw1_i,
    input wire logic [2:0] vssa_in_window_i,
    input wire logic [2:0] vssb_in_window_i,
    input wire logic [3:0] reset_event_i,
    output logic sdo_o,
    output logic sdo_oe_n_o,
    output logic amp_enable_output_o,
    output logic amp_enable_output_oe_n_o,
    output logic multi_function_pin_o,
    output logic multi_function_pin_oe_n_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] glob;
        logic [15:0] adc_ovr;
        logic [15:0] pwr;
        logic [15:0] sdo_cfg;
        logic [15:0] cfg0;
        logic [15:0] cfg1;
        logic [15:0] asrc0;
        logic [15:0] asrc1;
        logic [15:0] byp0;
        logic [15:0] byp1;
        logic [15:0] psrc0;
        logic [15:0] psrc1;
        logic [3:0] rflags;
        logic [15:0] read_word;
        logic [2:0] sync;
        logic global_alarm_flag;
        logic pin_latch;
        logic shut_latch;
        logic amp_out;
        logic amp_oe_n;
        logic mp_out;
        logic mp_oe_n;
    } state_s;

    state_s st_reg, st_next;
    pa_mon_pkg::frame_s frame;
    logic done_tgl;
    logic frame_seen;
    logic status_read;
    logic [15:0] rdata;
    logic [15:0] eff0, eff1, raw1_win;
    logic vssa_alarm, vssb_alarm;
    logic cond_any, pin_cond, shut_cond;
    logic amp_on, amp_level, mp_level;
    logic [15:0] adc_sel [5];

    // ------------------------------------------------------------
    // Serial link
    // ------------------------------------------------------------
    spi_link_port u_link (
        .sclk_i(sclk_i),
        .cs_n_i(cs_n_i),
        .sdi_i(sdi_i),
        .reset_n_i(reset_n_i),
        .early_i(st_reg.sdo_cfg[pa_mon_pkg::SDO_EARLY_BIT]),
        .read_word_i(st_reg.read_word),
        .sdo_o(sdo_o),
        .frame_o(frame),
        .done_tgl_o(done_tgl)
    );

    assign sdo_oe_n_o = ~(st_reg.sdo_cfg[pa_mon_pkg::SERIAL_OUT_CONTROL_BIT] & ~i2c_mode_i
        & ~cs_n_i);

    // ------------------------------------------------------------
    // Alarm path
    // ------------------------------------------------------------
    always_comb begin
        vssa_alarm = ~|(st_reg.cfg1[pa_mon_pkg::VSSA_LO +: 3] & vssa_in_window_i);
        vssb_alarm = ~|(st_reg.cfg1[pa_mon_pkg::VSSB_LO +: 3] & vssb_in_window_i);
        raw1_win = alarm_raw1_i;
        raw1_win[pa_mon_pkg::VSSA_ALM_BIT] = vssa_alarm;
        raw1_win[pa_mon_pkg::VSSB_ALM_BIT] = vssb_alarm;
        if (st_reg.glob[pa_mon_pkg::GLB_ALARM_OVR]) begin
            eff0 = st_reg.byp0;
            eff1 = st_reg.byp1;
        end else begin
            eff0 = alarm_raw0_i & pa_mon_pkg::MASK_ALM0;
            eff1 = raw1_win & pa_mon_pkg::MASK_ALM1;
        end
        cond_any = |{eff0, eff1};
        pin_cond = |{eff0 & st_reg.asrc0, eff1 & st_reg.asrc1};
        shut_cond = |{eff0 & st_reg.psrc0, eff1 & st_reg.psrc1};
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        adc_sel[0] = adc_i.sense0;
        adc_sel[1] = adc_i.sense1;
        adc_sel[2] = adc_i.hv0;
        adc_sel[3] = adc_i.hv1;
        adc_sel[4] = adc_i.temp;
        if (st_reg.glob[pa_mon_pkg::GLB_ADC_OVR]) begin
            for (int i = 0; i < 5; i++) begin
                adc_sel[i] = st_reg.adc_ovr;
            end
        end
        unique case (frame.addr)
            pa_mon_pkg::ADDR_PWR: rdata = st_reg.pwr;
            pa_mon_pkg::ADDR_GLOBAL: rdata = st_reg.glob;
            pa_mon_pkg::ADDR_SENSE0: rdata = adc_sel[0];
            pa_mon_pkg::ADDR_SENSE1: rdata = adc_sel[1];
            pa_mon_pkg::ADDR_HV0: rdata = adc_sel[2];
            pa_mon_pkg::ADDR_HV1: rdata = adc_sel[3];
            pa_mon_pkg::ADDR_TEMP: rdata = adc_sel[4];
            pa_mon_pkg::ADDR_STATUS: rdata = {14'h0000, ~st_reg.shut_latch, st_reg.global_alarm_flag};
            pa_mon_pkg::ADDR_ALM_STAT0: rdata = eff0;
            pa_mon_pkg::ADDR_ALM_STAT1: rdata = eff1;
            pa_mon_pkg::ADDR_ADC_OVR: rdata = st_reg.adc_ovr;
            pa_mon_pkg::ADDR_ID: rdata = DEVICE_ID;
            pa_mon_pkg::ADDR_VER: rdata = {12'h000, REVISION};
            pa_mon_pkg::ADDR_SDO: rdata = st_reg.sdo_cfg;
            pa_mon_pkg::ADDR_CFG0: rdata = st_reg.cfg0;
            pa_mon_pkg::ADDR_CFG1: rdata = st_reg.cfg1;
            pa_mon_pkg::ADDR_ASRC0: rdata = st_reg.asrc0;
            pa_mon_pkg::ADDR_ASRC1: rdata = st_reg.asrc1;
            pa_mon_pkg::ADDR_BYP0: rdata = st_reg.byp0;
            pa_mon_pkg::ADDR_BYP1: rdata = st_reg.byp1;
            pa_mon_pkg::ADDR_PSRC0: rdata = st_reg.psrc0;
            pa_mon_pkg::ADDR_PSRC1: rdata = st_reg.psrc1;
            pa_mon_pkg::ADDR_RFLAGS: rdata = {12'h000, st_reg.rflags};
            default: rdata = pa_mon_pkg::ZERO16;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [15:0] wd;
    always_comb begin
        st_next = st_reg;
        wd = frame.data;
        st_next.sync = {st_reg.sync[1:0], done_tgl};
        frame_seen = st_reg.sync[2] ^ st_reg.sync[1];
        status_read = frame_seen & frame.rd & (frame.addr == pa_mon_pkg::ADDR_STATUS);
        if (frame_seen && frame.rd) begin
            st_next.read_word = rdata;
        end
        if (frame_seen && !frame.rd) begin
            unique case (frame.addr)
                pa_mon_pkg::ADDR_PWR: st_next.pwr = wd & pa_mon_pkg::MASK_PWR;
                pa_mon_pkg::ADDR_GLOBAL: st_next.glob = wd & pa_mon_pkg::MASK_GLOBAL;
                pa_mon_pkg::ADDR_ADC_OVR: st_next.adc_ovr = wd;
                pa_mon_pkg::ADDR_SDO: st_next.sdo_cfg = wd & pa_mon_pkg::MASK_SDO;
                pa_mon_pkg::ADDR_CFG0: st_next.cfg0 = wd & pa_mon_pkg::MASK_CFG0;
                pa_mon_pkg::ADDR_CFG1: st_next.cfg1 = wd & pa_mon_pkg::MASK_CFG1;
                pa_mon_pkg::ADDR_ASRC0: st_next.asrc0 = wd & pa_mon_pkg::MASK_ALM0;
                pa_mon_pkg::ADDR_ASRC1: st_next.asrc1 = wd & pa_mon_pkg::MASK_SRC1;
                pa_mon_pkg::ADDR_BYP0: st_next.byp0 = wd & pa_mon_pkg::MASK_ALM0;
                pa_mon_pkg::ADDR_BYP1: st_next.byp1 = wd & pa_mon_pkg::MASK_ALM1;
                pa_mon_pkg::ADDR_PSRC0: st_next.psrc0 = wd & pa_mon_pkg::MASK_ALM0;
                pa_mon_pkg::ADDR_PSRC1: st_next.psrc1 = wd & pa_mon_pkg::MASK_SRC1;
                pa_mon_pkg::ADDR_RFLAGS: st_next.rflags = st_reg.rflags
                    & wd[pa_mon_pkg::RFLAG_W-1:0];
                default: st_next.pwr = st_reg.pwr;
            endcase
        end
        st_next.rflags = st_next.rflags | reset_event_i;
        if (st_reg.cfg0[pa_mon_pkg::HOLD_DIS_BIT]) begin
            st_next.global_alarm_flag = cond_any;
            st_next.pin_latch = pin_cond;
            st_next.shut_latch = shut_cond;
        end else begin
            st_next.global_alarm_flag = cond_any | (st_reg.global_alarm_flag & ~status_read);
            st_next.pin_latch = pin_cond | (st_reg.pin_latch & ~status_read);
            st_next.shut_latch = shut_cond | (st_reg.shut_latch & ~status_read);
        end
        amp_on = st_reg.pwr[pa_mon_pkg::PWR_AMP_BIT] & ~st_reg.shut_latch;
        amp_level = st_reg.cfg0[pa_mon_pkg::AMP_POL_BIT] ? ~amp_on : amp_on;
        if (st_reg.cfg0[pa_mon_pkg::AMP_OD_BIT]) begin
            st_next.amp_out = 1'b0;
            st_next.amp_oe_n = amp_level;
        end else begin
            st_next.amp_out = amp_level;
            st_next.amp_oe_n = 1'b0;
        end
        mp_level = st_reg.cfg0[pa_mon_pkg::MP_POL_BIT] ? st_reg.pin_latch
            : ~st_reg.pin_latch;
        st_next.mp_out = 1'b0;
        st_next.mp_oe_n = 1'b1;
        if (st_reg.cfg1[5:0] == pa_mon_pkg::FUNC_ALARM_OUT) begin
            if (st_reg.cfg0[pa_mon_pkg::MP_OD_BIT]) begin
                st_next.mp_oe_n = mp_level;
            end else begin
                st_next.mp_out = mp_level;
                st_next.mp_oe_n = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            st_reg <= '0;
            st_reg.cfg0 <= pa_mon_pkg::RST_CFG0;
            st_reg.cfg1 <= pa_mon_pkg::RST_CFG1;
            st_reg.asrc1 <= pa_mon_pkg::RST_SRC1;
            st_reg.psrc1 <= pa_mon_pkg::RST_SRC1;
            st_reg.rflags <= pa_mon_pkg::RST_RFLAGS[3:0];
            st_reg.mp_oe_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign amp_enable_output_o = st_reg.amp_out;
    assign amp_enable_output_oe_n_o = st_reg.amp_oe_n;
    assign multi_function_pin_o = st_reg.mp_out;
    assign multi_function_pin_oe_n_o = st_reg.mp_oe_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_adc_override;
        frame_seen && frame.rd && frame.addr == pa_mon_pkg::ADDR_TEMP
            && st_reg.glob[pa_mon_pkg::GLB_ADC_OVR] |=> st_reg.read_word == $past(st_reg.adc_ovr);
    endproperty
    a_adc_override: assert property (p_adc_override) else $error("override not read");

    property p_hv_live;
        frame_seen && frame.rd && frame.addr == pa_mon_pkg::ADDR_HV0
            && !st_reg.glob[pa_mon_pkg::GLB_ADC_OVR] |=> st_reg.read_word == $past(adc_i.hv0);
    endproperty
    a_hv_live: assert property (p_hv_live) else $error("live result not read");

    property p_alarm_force;
        st_reg.glob[pa_mon_pkg::GLB_ALARM_OVR] |-> eff0 == st_reg.byp0 && eff1 == st_reg.byp1;
    endproperty
    a_alarm_force: assert property (p_alarm_force) else $error("alarm not forced");

    property p_vssb_window;
        !st_reg.glob[pa_mon_pkg::GLB_ALARM_OVR]
            && !(|(st_reg.cfg1[pa_mon_pkg::VSSB_LO +: 3] & vssb_in_window_i))
            |-> eff1[pa_mon_pkg::VSSB_ALM_BIT];
    endproperty
    a_vssb_window: assert property (p_vssb_window) else $error("supply alarm missed");

    property p_hold;
        st_reg.global_alarm_flag && !st_reg.cfg0[pa_mon_pkg::HOLD_DIS_BIT] && !status_read |=> st_reg.global_alarm_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("held alarm dropped");

    property p_nohold;
        st_reg.cfg0[pa_mon_pkg::HOLD_DIS_BIT] && !cond_any |=> !st_reg.global_alarm_flag;
    endproperty
    a_nohold: assert property (p_nohold) else $error("unheld alarm stuck");

    property p_amp_push;
        !st_reg.cfg0[pa_mon_pkg::AMP_OD_BIT] && !st_reg.cfg0[pa_mon_pkg::AMP_POL_BIT]
            |=> amp_enable_output_o == $past(amp_on) && !amp_enable_output_oe_n_o;
    endproperty
    a_amp_push: assert property (p_amp_push) else $error("amp pin wrong");

    property p_amp_od;
        st_reg.cfg0[pa_mon_pkg::AMP_OD_BIT] |=> !amp_enable_output_o;
    endproperty
    a_amp_od: assert property (p_amp_od) else $error("amp pin driven high");

    property p_mp_od;
        st_reg.cfg1[5:0] == pa_mon_pkg::FUNC_ALARM_OUT && st_reg.cfg0[pa_mon_pkg::MP_OD_BIT]
            |=> !multi_function_pin_o;
    endproperty
    a_mp_od: assert property (p_mp_od) else $error("multi pin driven high");

    property p_flag_set;
        reset_event_i != 4'h0 |=> (st_reg.rflags & $past(reset_event_i)) == $past(reset_event_i);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("cause flag lost");

    property p_sdo_quiet;
        !st_reg.sdo_cfg[pa_mon_pkg::SERIAL_OUT_CONTROL_BIT] || i2c_mode_i || cs_n_i |-> sdo_oe_n_o;
    endproperty
    a_sdo_quiet: assert property (p_sdo_quiet) else $error("data out driven");

    property p_mp_released;
        st_reg.cfg1[5:0] != pa_mon_pkg::FUNC_ALARM_OUT |=> multi_function_pin_oe_n_o;
    endproperty
    a_mp_released: assert property (p_mp_released) else $error("multi pin driven");

    property p_amp_invert;
        !st_reg.cfg0[pa_mon_pkg::AMP_OD_BIT] && st_reg.cfg0[pa_mon_pkg::AMP_POL_BIT]
            |=> amp_enable_output_o == !$past(amp_on);
    endproperty
    a_amp_invert: assert property (p_amp_invert) else $error("amp pin not inverted");

    property p_flag_arm;
        frame_seen && !frame.rd && frame.addr == pa_mon_pkg::ADDR_RFLAGS
            && reset_event_i == 4'h0
            |=> ({12'h000, st_reg.rflags} & ~$past(frame.data)) == pa_mon_pkg::ZERO16;
    endproperty
    a_flag_arm: assert property (p_flag_arm) else $error("cause flag not armed");

    property p_cfg0_reserved;
        frame_seen && !frame.rd && frame.addr == pa_mon_pkg::ADDR_CFG0
            |=> (st_reg.cfg0 & ~pa_mon_pkg::MASK_CFG0) == pa_mon_pkg::ZERO16;
    endproperty
    a_cfg0_reserved: assert property (p_cfg0_reserved) else $error("reserved bit set");
endmodule
`default_nettype wire

// File: bench/spi_host_model.sv
// Purpose: Host end of the serial link for the register bank bench
// Assumes: Serial clock idles high, 125 ns period, runs only inside frames
// Notes: Returns the 24 bits seen on the data-out line during a frame
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic sdo_i,
    input wire logic early_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o
);
    // ------------------------------------------------------------
    // Frame transfer
    // ------------------------------------------------------------
    initial begin
        sclk_o = 1'b1;
        cs_n_o <= 1'b1;
        sdi_o = 1'b0;
    end
    task automatic xfer(input logic [23:0] word, output logic [23:0] got);
        got = 24'h000000;
        cs_n_o = 1'b0;
        #10;
        if (early_i) got = {got[22:0], sdo_i};
        for (int i = 23; i >= 0; i--) begin
            sdi_o = word[i];
            #62.5;
            if (!early_i) got = {got[22:0], sdo_i};
            sclk_o = 1'b0;
            #62.5;
            if (early_i && i > 0) got = {got[22:0], sdo_i};
            sclk_o = 1'b1;
        end
        #62.5;
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #500;
    endtask
endmodule
`default_nettype wire

// File: bench/pa_monitor_general_config_regs_tb.sv
// Purpose: Self-checking bench of the monitor register bank
// Assumes: Host model drives the link; register clock 50 MHz
// Notes: Register rows first, pin and alarm cases after
`timescale 1ns/1ps
`default_nettype none
module pa_monitor_general_config_regs_tb;
    typedef struct packed {logic w; logic [6:0] a; logic [15:0] d; logic [15:0] want;} row_s;
    logic ref_clk_i = 1'b0;
    logic reset_n_i;
    logic early = 1'b0;
    pa_mon_pkg::adc_in_s adc_i = 80'h8001_7FFF_1234_0001_FF80;
    logic [15:0] alarm_raw1 = 16'h0000;
    logic [5:0] windows = 6'h3F;
    logic [3:0] events = 4'h0;
    logic sclk, cs_n, sdi, sdo, sdo_oe_n, amp, amp_oe_n, mp, mp_oe_n;
    wire sdo_w = sdo_oe_n ? ~sdo : sdo;
    logic [23:0] got;
    int bad_count = 0;
    int cmp_count = 0;
    row_s rows [22] = '{'{1, 7'h42, 16'h0001, 16'h0001}, '{0, 7'h44, 0, 16'h0010},
        '{0, 7'h45, 0, 16'h1101}, '{0, 7'h49, 0, 16'h1833},
        '{0, 7'h51, 0, 16'h1833}, '{0, 7'h70, 0, 16'h000F},
        '{1, 7'h40, 0, 16'h5A5A}, '{1, 7'h41, 16'hFFFF, 16'h0007},
        '{1, 7'h18, 0, 16'h8001}, '{0, 7'h1A, 0, 16'h1234}, '{0, 7'h1C, 0, 16'hFF80},
        '{1, 7'h44, 16'hFFFF, 16'hC038}, '{1, 7'h44, 16'h0010, 16'h0010},
        '{1, 7'h48, 16'hFFFF, 16'h0133}, '{1, 7'h4C, 16'hFFFF, 16'h0133},
        '{1, 7'h4D, 16'hFFFF, 16'h3833}, '{1, 7'h45, 16'hFFFF, 16'h773F},
        '{1, 7'h45, 16'h1102, 16'h1102}, '{1, 7'h23, 16'hABCD, 16'hABCD},
        '{1, 7'h17, 16'h0002, 16'h0002}, '{0, 7'h1C, 0, 16'hABCD},
        '{1, 7'h70, 0, 0}};
    spi_host_model host (.sdo_i(sdo_w), .early_i(early), .sclk_o(sclk), .cs_n_o(cs_n),
        .sdi_o(sdi));
    pa_monitor_general_config_regs uut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .i2c_mode_i(1'b0), .adc_i(adc_i),
        .alarm_raw0_i(16'h0000), .alarm_raw1_i(alarm_raw1), .vssa_in_window_i(windows[2:0]),
        .vssb_in_window_i(windows[5:3]), .reset_event_i(events), .sdo_o(sdo),
        .sdo_oe_n_o(sdo_oe_n), .amp_enable_output_o(amp), .amp_enable_output_oe_n_o(amp_oe_n),
        .multi_function_pin_o(mp), .multi_function_pin_oe_n_o(mp_oe_n));
    // ------------------------------------------------------------
    // Clock, helpers and closing
    // ------------------------------------------------------------
    always #10 ref_clk_i = ~ref_clk_i;
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] v);
        host.xfer({1'b0, a, v}, got);
        repeat (6) @(posedge ref_clk_i);
    endtask
    task automatic rd(input logic [6:0] a);
        host.xfer({1'b1, a, 16'h0000}, got);
        host.xfer({1'b0, 7'h40, 16'h0000}, got);
        repeat (6) @(posedge ref_clk_i);
    endtask
    task automatic print_verdict;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        bad_count++;
        print_verdict;
    end
    initial begin
        reset_n_i <= 1'b0;
        repeat (16) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        @(posedge ref_clk_i);
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rd(rows[i].a);
            check(got[15:0], rows[i].want);
        end
        early = 1'b1;
        wr(7'h42, 16'h0003);
        rd(7'h45);
        check(got[15:0], 16'h1102);
        early = 1'b0;
        wr(7'h42, 16'h0001);
        wr(7'h08, 16'h0100);
        check({14'h0, amp, amp_oe_n}, 16'h0002);
        wr(7'h44, 16'h8010);
        check({15'h0, amp}, 16'h0000);
        wr(7'h44, 16'h4010);
        check({15'h0, amp_oe_n}, 16'h0001);
        wr(7'h44, 16'h0010);
        @(posedge ref_clk_i) alarm_raw1 <= 16'h0001;
        wr(7'h17, 16'h0000);
        check({12'h0, amp, amp_oe_n, mp, mp_oe_n}, 16'h0000);
        @(posedge ref_clk_i) alarm_raw1 <= 16'h0000;
        wr(7'h17, 16'h0000);
        check({15'h0, mp_oe_n}, 16'h0000);
        rd(7'h20);
        check({15'h0, got[0], mp_oe_n}, 16'h0003);
        wr(7'h44, 16'h0018);
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk_i) windows <= k ? 6'h3E : 6'h37;
            repeat (8) @(posedge ref_clk_i);
            check({15'h0, mp_oe_n}, 16'h0000);
            @(posedge ref_clk_i) windows <= 6'h3F;
            repeat (8) @(posedge ref_clk_i);
            check({15'h0, mp_oe_n}, 16'h0001);
        end
        wr(7'h17, 16'h0001);
        check({15'h0, mp_oe_n}, 16'h0000);
        wr(7'h4D, 16'h0000);
        wr(7'h4C, 16'h0000);
        check({15'h0, mp_oe_n}, 16'h0001);
        @(posedge ref_clk_i) events <= 4'h4;
        @(posedge ref_clk_i) events <= 4'h0;
        rd(7'h70);
        check(got[15:0], 16'h0004);
        print_verdict;
    end
endmodule
`default_nettype wire
